// *** hdl/timer8.sv ***
// 8-bit timer/counter with two compare channels, APB register slave.
// Assumes pins synchronous to pclk and an APB master on the bus side.
`include "timer8_defs.svh"
`default_nettype none
module timer8 import timer8_pkg::*; #(
  parameter int ADDR_WIDTH = 12,
  parameter int PRESCALE_WIDTH = `DIV1024_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_pin,
  input wire logic power_reduce_bit,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_request,
  output logic compare_output_a,
  output logic compare_output_b
);
  // ==========================================================
  // Bus decode
  logic [7:0] control_reg_a;
  logic [3:0] control_reg_b;
  logic [7:0] counter_value;
  logic [7:0] irq_flag_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] cmp_active [0:1];
  logic [7:0] cmp_buffer [0:1];
  logic [7:0] read_mux;
  timer_cfg_t cfg;
  dir_t dir;
  dir_t next_dir;
  logic [7:0] next_counter;
  logic block;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic pin_sample;
  logic pin_prev;
  logic [1:0] oc;
  wire [11:0] addr = 12'(paddr);
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire sel_ctrl_a = addr == `OFS_CONTROL_A;
  wire sel_ctrl_b = addr == `OFS_CONTROL_B;
  wire sel_counter = addr == `OFS_COUNTER;
  wire sel_cmp_a = addr == `OFS_COMPARE_A;
  wire sel_cmp_b = addr == `OFS_COMPARE_B;
  wire sel_flags = addr == `OFS_FLAGS;
  wire sel_mask = addr == `OFS_MASK;
  wire addr_hit = sel_ctrl_a | sel_ctrl_b | sel_counter | sel_cmp_a | sel_cmp_b
                  | sel_flags | sel_mask;
  wire wr_counter = wr & sel_counter;
  wire wr_flags = wr & sel_flags;
  wire [1:0] wr_cmp = {wr & sel_cmp_b, wr & sel_cmp_a};
  wire [7:0] wdata = pwdata[7:0];
  // ==========================================================
  // Mode decode
  assign cfg.com_a = control_reg_a[`CA_COM_A_LSB +: 2];
  assign cfg.com_b = control_reg_a[`CA_COM_B_LSB +: 2];
  assign cfg.wgm = {control_reg_b[`CB_WGM2], control_reg_a[`CA_WGM_LSB +: 2]};
  assign cfg.cs = control_reg_b[`CB_CS_LSB +: 3];
  wire is_pwm = cfg.wgm[0];
  wire is_phase = cfg.wgm == `WGM_PHASE_MAX || cfg.wgm == `WGM_PHASE_A;
  wire is_fast = cfg.wgm == `WGM_FAST_MAX || cfg.wgm == `WGM_FAST_A;
  wire is_ctc = cfg.wgm == `WGM_CTC;
  wire top_is_a = cfg.wgm == `WGM_PHASE_A || cfg.wgm == `WGM_FAST_A;
  wire [7:0] top_value = top_is_a ? cmp_active[0] : `VALUE_MAX;
  wire at_top = counter_value == top_value;
  wire at_bottom = counter_value == `VALUE_BOTTOM;
  wire at_max = counter_value == `VALUE_MAX;
  // ==========================================================
  // Tick generation
  wire tap_8 = &prescale[`DIV8_BITS-1:0];
  wire tap_64 = &prescale[`DIV64_BITS-1:0];
  wire tap_256 = &prescale[`DIV256_BITS-1:0];
  wire tap_1024 = &prescale[`DIV1024_BITS-1:0];
  wire pin_rise = pin_sample & ~pin_prev;
  wire pin_fall = ~pin_sample & pin_prev;
  wire raw_tick = cfg.cs == `CS_DIRECT ? 1'b1 :
                  cfg.cs == `CS_DIV8 ? tap_8 :
                  cfg.cs == `CS_DIV64 ? tap_64 :
                  cfg.cs == `CS_DIV256 ? tap_256 :
                  cfg.cs == `CS_DIV1024 ? tap_1024 :
                  cfg.cs == `CS_PIN_FALL ? pin_fall :
                  cfg.cs == `CS_PIN_RISE ? pin_rise : 1'b0;
  wire timer_tick = raw_tick & ~power_reduce_bit;
  // ==========================================================
  // Compare channels
  logic [1:0] match;
  logic [1:0] hit;
  logic [1:0] force_now;
  logic [1:0] com_sel [0:1];
  assign com_sel[0] = cfg.com_a;
  assign com_sel[1] = cfg.com_b;
  assign force_now[0] = wr & sel_ctrl_b & pwdata[`CB_FORCE_A] & ~is_pwm;
  assign force_now[1] = wr & sel_ctrl_b & pwdata[`CB_FORCE_B] & ~is_pwm;
  wire update_evt = timer_tick & at_top & is_pwm;
  genvar n;
  generate
    for (n = 0; n < 2; n++) begin : g_chan
      logic next_oc;
      assign match[n] = counter_value == cmp_active[n];
      assign hit[n] = timer_tick & match[n] & ~block & ~wr_counter;
      always_comb begin
        next_oc = oc[n];
        if (!is_pwm) begin
          if (hit[n] || force_now[n]) begin
            case (com_sel[n])
              `COM_TOGGLE: next_oc = ~oc[n];
              `COM_CLEAR: next_oc = 1'b0;
              `COM_SET: next_oc = 1'b1;
              default: next_oc = oc[n];
            endcase
          end
        end else if (com_sel[n][1]) begin
          if (is_fast && timer_tick && at_top) begin
            next_oc = ~com_sel[n][0];
          end else if (is_fast && hit[n]) begin
            next_oc = com_sel[n][0];
          end else if (is_phase && hit[n]) begin
            next_oc = (dir == DIR_UP) ? com_sel[n][0] : ~com_sel[n][0];
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmp_active[n] <= `RST_BYTE;
          cmp_buffer[n] <= `RST_BYTE;
          oc[n] <= 1'b0;
        end else begin
          oc[n] <= next_oc;
          if (wr_cmp[n]) begin
            cmp_buffer[n] <= wdata;
          end
          if (wr_cmp[n] && !is_pwm) begin
            cmp_active[n] <= wdata;
          end else if (update_evt) begin
            cmp_active[n] <= cmp_buffer[n];
          end
        end
      end
    end
  endgenerate
  assign compare_output_a = oc[0];
  assign compare_output_b = oc[1];
  // ==========================================================
  // Counter unit
  always_comb begin
    next_counter = counter_value;
    next_dir = dir;
    if (wr_counter) begin
      next_counter = wdata;
    end else if (timer_tick) begin
      if (is_phase) begin
        case (dir)
          DIR_UP: begin
            next_counter = at_top ? counter_value - 8'h01 : counter_value + 8'h01;
            next_dir = at_top ? DIR_DOWN : DIR_UP;
          end
          DIR_DOWN: begin
            next_counter = at_bottom ? counter_value + 8'h01 : counter_value - 8'h01;
            next_dir = at_bottom ? DIR_UP : DIR_DOWN;
          end
          default: next_dir = DIR_UP;
        endcase
      end else if (is_fast) begin
        next_counter = at_top ? `VALUE_BOTTOM : counter_value + 8'h01;
        next_dir = DIR_UP;
      end else if (is_ctc && match[0] && !block) begin
        next_counter = `VALUE_BOTTOM;
      end else begin
        next_counter = counter_value + 8'h01;
      end
    end
    if (!is_phase) begin
      next_dir = DIR_UP;
    end
  end
  wire ovf_evt = timer_tick & ~wr_counter &
                 (is_phase ? at_bottom : is_fast ? at_top : at_max);
  // ==========================================================
  // Flags and requests
  wire [2:0] flag_set = {hit[1], hit[0], ovf_evt};
  wire [2:0] flag_clr = (wr_flags ? pwdata[2:0] : 3'h0) | irq_ack;
  wire [2:0] next_flags = (irq_flag_reg[2:0] & ~flag_clr) | flag_set;
  assign irq_request = irq_flag_reg[2:0] & irq_mask_reg[2:0];
  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= `RST_BYTE;
      dir <= DIR_UP;
      block <= 1'b0;
      prescale <= '0;
      pin_sample <= 1'b0;
      pin_prev <= 1'b0;
      irq_flag_reg <= `RST_BYTE;
    end else begin
      counter_value <= next_counter;
      dir <= next_dir;
      block <= wr_counter | (block & ~timer_tick);
      prescale <= prescale + PRESCALE_WIDTH'(1);
      pin_sample <= external_count_pin;
      pin_prev <= pin_sample;
      irq_flag_reg <= {5'h00, next_flags};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_a <= `RST_BYTE;
      control_reg_b <= 4'h0;
      irq_mask_reg <= `RST_BYTE;
    end else if (wr) begin
      if (sel_ctrl_a) control_reg_a <= wdata;
      if (sel_ctrl_b) control_reg_b <= wdata[3:0];
      if (sel_mask) irq_mask_reg <= {5'h00, wdata[2:0]};
    end
  end
  // ==========================================================
  // Read path
  assign read_mux = sel_ctrl_a ? control_reg_a :
                    sel_ctrl_b ? {4'h0, control_reg_b} :
                    sel_counter ? counter_value :
                    sel_cmp_a ? (is_pwm ? cmp_buffer[0] : cmp_active[0]) :
                    sel_cmp_b ? (is_pwm ? cmp_buffer[1] : cmp_active[1]) :
                    sel_flags ? irq_flag_reg :
                    sel_mask ? irq_mask_reg : `RST_BYTE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= `RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h00_0000, read_mux};
    end
  end
  assign pready = 1'b1;
  assign pslverr = access & ~addr_hit;
  // ==========================================================
  // Checks
  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.cs == `CS_STOP && !wr_counter) |=> $stable(counter_value))
    else $error("counter moved while stopped");
  a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
    wr_counter |=> counter_value == $past(pwdata[7:0]))
    else $error("counter write lost");
  a_normal_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.wgm == `WGM_NORMAL && timer_tick && at_max && !wr_counter)
      |=> counter_value == 8'h00 && irq_flag_reg[`FLAG_OVF])
    else $error("normal mode wrap wrong");
  a_ctc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (is_ctc && timer_tick && match[0] && !block && !wr_counter)
      |=> counter_value == 8'h00)
    else $error("ctc clear missing");
  a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_tick && match[0] && !block && !wr_counter) |=> irq_flag_reg[`FLAG_MATCH_A])
    else $error("match flag not set");
  a_match_b_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_tick && match[1] && !block && !wr_counter) |=> irq_flag_reg[`FLAG_MATCH_B])
    else $error("match b flag not set");
  a_block_match: assert property (@(posedge pclk) disable iff (!presetn)
    (block && timer_tick && !irq_flag_reg[`FLAG_MATCH_B])
      |=> !irq_flag_reg[`FLAG_MATCH_B])
    else $error("blocked match set flag");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_ack[0] && !ovf_evt) |=> !irq_flag_reg[`FLAG_OVF])
    else $error("serviced flag not cleared");
  a_buffer_sync: assert property (@(posedge pclk) disable iff (!presetn)
    (is_pwm && !update_evt) |=> $stable(cmp_active[0]) && $stable(cmp_active[1]))
    else $error("active compare changed off top");
  a_force_noflag: assert property (@(posedge pclk) disable iff (!presetn)
    (force_now[0] && !hit[0] && !wr_flags && !irq_ack[1])
      |=> $stable(irq_flag_reg[`FLAG_MATCH_A]))
    else $error("force changed flag");
  a_request_rise: assert property (@(posedge pclk) disable iff (!presetn)
    (ovf_evt && irq_mask_reg[`FLAG_OVF] && !(wr && sel_mask))
      |=> irq_request[`FLAG_OVF])
    else $error("overflow request missing");
  // ==========================================================
  // Waveform, tick and buffering checks
  a_force_output: assert property (@(posedge pclk) disable iff (!presetn)
    (force_now[1] && cfg.com_b == `COM_SET) |=> compare_output_b)
    else $error("forced set missing");
  a_phase_bottom: assert property (@(posedge pclk) disable iff (!presetn)
    (is_phase && timer_tick && at_bottom && !wr_counter) |=> irq_flag_reg[`FLAG_OVF])
    else $error("phase overflow missing");
  a_phase_turn: assert property (@(posedge pclk) disable iff (!presetn)
    (is_phase && timer_tick && at_top && dir == DIR_UP && !wr_counter)
      |=> dir == DIR_DOWN)
    else $error("phase turn missing");
  a_fast_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (is_fast && timer_tick && at_top && !wr_counter) |=> counter_value == 8'h00)
    else $error("fast wrap missing");
  a_power_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (power_reduce_bit && !wr_counter) |=> $stable(counter_value))
    else $error("counter moved while powered down");
  a_pin_count: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.cs == `CS_PIN_RISE && pin_sample && !pin_prev && !power_reduce_bit
      && cfg.wgm == `WGM_NORMAL && !wr_counter)
      |=> counter_value == $past(counter_value) + 8'h01)
    else $error("pin edge not counted");
  a_direct_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_cmp[0] && !is_pwm) |=> cmp_active[0] == $past(pwdata[7:0]))
    else $error("direct compare write lost");
  c_ctc_wrap: cover property (@(posedge pclk) disable iff (!presetn)
    is_ctc && timer_tick && match[0] ##1 counter_value == 8'h00);
  c_phase_turn: cover property (@(posedge pclk) disable iff (!presetn)
    dir == DIR_UP ##1 dir == DIR_DOWN);
  c_force: cover property (@(posedge pclk) disable iff (!presetn) force_now[0]);
  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) ovf_evt);
  c_buffer_update: cover property (@(posedge pclk) disable iff (!presetn) update_evt);
endmodule
`default_nettype wire

// *** hdl/timer8_defs.svh ***
// Offsets, field positions, reset values and counts of the 8-bit timer.
// Assumes inclusion by bare name from the timer design file.
`ifndef TIMER8_DEFS_SVH
`define TIMER8_DEFS_SVH
// ==========================================================
// Register byte offsets
`define OFS_CONTROL_A 12'h000
`define OFS_CONTROL_B 12'h004
`define OFS_COUNTER 12'h008
`define OFS_COMPARE_A 12'h00C
`define OFS_COMPARE_B 12'h010
`define OFS_FLAGS 12'h014
`define OFS_MASK 12'h018
// ==========================================================
// Field positions
`define CA_COM_A_LSB 6
`define CA_COM_B_LSB 4
`define CA_WGM_LSB 0
`define CB_FORCE_A 7
`define CB_FORCE_B 6
`define CB_WGM2 3
`define CB_CS_LSB 0
`define FLAG_OVF 0
`define FLAG_MATCH_A 1
`define FLAG_MATCH_B 2
// ==========================================================
// Reset values and counter boundaries
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define VALUE_BOTTOM 8'h00
`define VALUE_MAX 8'hFF
// ==========================================================
// Prescaler tap widths: divisions of 8, 64, 256 and 1024
`define DIV8_BITS 3
`define DIV64_BITS 6
`define DIV256_BITS 8
`define DIV1024_BITS 10
// ==========================================================
// Clock select and waveform mode codes
`define CS_STOP 3'h0
`define CS_DIRECT 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_PIN_FALL 3'h6
`define CS_PIN_RISE 3'h7
`define WGM_NORMAL 3'h0
`define WGM_PHASE_MAX 3'h1
`define WGM_CTC 3'h2
`define WGM_FAST_MAX 3'h3
`define WGM_PHASE_A 3'h5
`define WGM_FAST_A 3'h7
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3
`endif

// *** hdl/timer8_pkg.sv ***
// Types shared by the 8-bit timer.
// Assumes the constants header is compiled alongside.
`default_nettype none
package timer8_pkg;
  // ==========================================================
  // Counting direction, one-hot
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;
  // ==========================================================
  // Decoded configuration
  typedef struct packed {
    logic [1:0] com_a;
    logic [1:0] com_b;
    logic [2:0] wgm;
    logic [2:0] cs;
  } timer_cfg_t;
  // ==========================================================
  // Flag and mask layout
  typedef struct packed {
    logic match_b;
    logic match_a;
    logic overflow;
  } irq_bits_t;
endpackage
`default_nettype wire

// *** tb/cpu_bus_model.sv ***
// APB master standing in for the CPU core on the timer's register port.
// Assumes a free-running pclk and a slave that answers with pready.
`default_nettype none
module cpu_bus_model (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // ==========================================================
  // One transfer: setup cycle, then access held until pready
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_eight_bit_timer_two_compare.sv ***
// Self-checking bench for the 8-bit timer: counting, flags, compare channels.
// Assumes timer8, its defs header and the APB master model are compiled.
`include "timer8_defs.svh"
`default_nettype none
module tb_eight_bit_timer_two_compare;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic external_count_pin, power_reduce_bit, compare_output_a, compare_output_b;
  logic [2:0] irq_ack, irq_request;
  logic [7:0] c, k, d;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  timer8 i_timer8 (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_count_pin, .power_reduce_bit, .irq_ack, .irq_request,
    .compare_output_a, .compare_output_b);
  cpu_bus_model i_cpu_bus_model (.pclk, .prdata, .pready, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata);
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    i_cpu_bus_model.xfer(1'b1, a, {24'h00_0000, v}, rdv, err);
  endtask
  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] e);
    i_cpu_bus_model.xfer(1'b0, a, 32'h0000_0000, rdv, err);
    check(what, rdv, {24'h00_0000, e});
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk);
      external_count_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      external_count_pin <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  function automatic logic [7:0] exp_count(input int s);
    int divs[5] = '{1, 8, 64, 256, 1024};
    return 8'(1024 / divs[s - 1]);
  endfunction
  task automatic test_done();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    external_count_pin = 1'b0;
    power_reduce_bit = 1'b0;
    irq_ack = 3'h0;
    void'($urandom(32'h0000_8ccb));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 24; a += 4) begin
      rd_chk("reset value", 12'(a), 8'h00);
    end
    i_cpu_bus_model.xfer(1'b0, 12'h01C, 32'h0000_0000, rdv, err);
    check("unmapped error", 32'(err), 32'h0000_0001);
    repeat (4) begin
      c = 8'($urandom);
      wr(`OFS_COUNTER, c);
      repeat (5) @(posedge pclk);
      rd_chk("stopped counter", `OFS_COUNTER, c);
    end
    // Normal mode wrap, overflow flag, mask and clears
    wr(`OFS_CONTROL_B, 8'h07);
    wr(`OFS_COUNTER, 8'hFE);
    pulse(2);
    rd_chk("wrapped counter", `OFS_COUNTER, 8'h00);
    rd_chk("overflow flag", `OFS_FLAGS, 8'h01);
    check("masked request", 32'(irq_request), 32'h0000_0000);
    wr(`OFS_MASK, 8'h07);
    @(posedge pclk);
    check("request", 32'(irq_request), 32'h0000_0001);
    wr(`OFS_FLAGS, 8'h01);
    rd_chk("flag one-write", `OFS_FLAGS, 8'h00);
    wr(`OFS_COUNTER, 8'hFF);
    pulse(1);
    rd_chk("overflow again", `OFS_FLAGS, 8'h01);
    @(posedge pclk);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    rd_chk("flag serviced", `OFS_FLAGS, 8'h00);
    // Match after counter write is blocked, later match sets flag
    c = 8'h10 + 8'($urandom % 224);
    wr(`OFS_COMPARE_A, c);
    wr(`OFS_COUNTER, c);
    wr(`OFS_FLAGS, 8'h07);
    pulse(1);
    rd_chk("blocked match", `OFS_FLAGS, 8'h00);
    rd_chk("count up", `OFS_COUNTER, c + 8'h01);
    wr(`OFS_COUNTER, c - 8'h01);
    pulse(2);
    rd_chk("match a flag", `OFS_FLAGS, 8'h02);
    // Clear on compare A
    k = 8'h03 + 8'($urandom % 6);
    wr(`OFS_CONTROL_A, 8'h02);
    wr(`OFS_COMPARE_A, k);
    wr(`OFS_COUNTER, 8'h00);
    wr(`OFS_FLAGS, 8'h07);
    pulse(32'(k) + 2);
    rd_chk("ctc counter", `OFS_COUNTER, 8'h01);
    rd_chk("ctc flags", `OFS_FLAGS, 8'h06);
    // Force strobe toggles output A or sets output B, output only
    wr(`OFS_CONTROL_A, 8'h40);
    wr(`OFS_CONTROL_B, 8'h00);
    wr(`OFS_FLAGS, 8'h07);
    wr(`OFS_CONTROL_B, 8'h80);
    repeat (2) @(posedge pclk);
    check("forced output", 32'(compare_output_a), 32'h0000_0001);
    rd_chk("force no flag", `OFS_FLAGS, 8'h00);
    rd_chk("force no reload", `OFS_COUNTER, 8'h01);
    wr(`OFS_CONTROL_B, 8'h80);
    repeat (2) @(posedge pclk);
    check("forced back", 32'(compare_output_a), 32'h0000_0000);
    check("output b idle", 32'(compare_output_b), 32'h0000_0000);
    wr(`OFS_CONTROL_A, 8'h30);
    wr(`OFS_CONTROL_B, 8'h40);
    repeat (2) @(posedge pclk);
    check("forced output b", 32'(compare_output_b), 32'h0000_0001);
    // Buffered compare in fast PWM
    wr(`OFS_CONTROL_A, 8'h03);
    wr(`OFS_CONTROL_B, 8'h07);
    wr(`OFS_COUNTER, 8'h10);
    wr(`OFS_COMPARE_B, 8'h11);
    rd_chk("buffer read", `OFS_COMPARE_B, 8'h11);
    wr(`OFS_FLAGS, 8'h07);
    pulse(3);
    rd_chk("buffer not active", `OFS_FLAGS, 8'h00);
    wr(`OFS_CONTROL_A, 8'h00);
    rd_chk("active read", `OFS_COMPARE_B, 8'h00);
    wr(`OFS_COMPARE_B, 8'h14);
    pulse(2);
    rd_chk("direct compare", `OFS_FLAGS, 8'h04);
    // Phase correct with top at compare A, overflow at bottom
    wr(`OFS_CONTROL_A, 8'h01);
    wr(`OFS_CONTROL_B, 8'h0F);
    wr(`OFS_COUNTER, k - 8'h01);
    pulse(3);
    rd_chk("phase turn", `OFS_COUNTER, k - 8'h02);
    wr(`OFS_COUNTER, 8'h01);
    wr(`OFS_FLAGS, 8'h07);
    pulse(2);
    rd_chk("phase bottom", `OFS_COUNTER, 8'h01);
    rd_chk("phase overflow", `OFS_FLAGS, 8'h01);
    wr(`OFS_CONTROL_A, 8'h00);
    // Pin edges select
    for (int s = 6; s <= 7; s++) begin
      wr(`OFS_CONTROL_B, 8'(s));
      wr(`OFS_COUNTER, 8'h00);
      @(posedge pclk);
      external_count_pin <= 1'b1;
      repeat (4) @(posedge pclk);
      rd_chk("pin rise", `OFS_COUNTER, 8'(s == 7));
      @(posedge pclk);
      external_count_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      rd_chk("pin fall", `OFS_COUNTER, 8'h01);
    end
    power_reduce_bit <= 1'b1;
    pulse(1);
    rd_chk("power reduced", `OFS_COUNTER, 8'h01);
    power_reduce_bit <= 1'b0;
    // Direct clock and prescaler taps
    for (int s = 1; s <= 5; s++) begin
      wr(`OFS_CONTROL_B, 8'h00);
      wr(`OFS_COUNTER, 8'h00);
      wr(`OFS_CONTROL_B, 8'(s));
      repeat (1024) @(posedge pclk);
      wr(`OFS_CONTROL_B, 8'h00);
      i_cpu_bus_model.xfer(1'b0, `OFS_COUNTER, 32'h0000_0000, rdv, err);
      d = rdv[7:0] - exp_count(s);
      check("prescaled count", 32'(d <= 8'h04 || d >= 8'hFE), 32'h0000_0001);
      repeat (8) @(posedge pclk);
      rd_chk("held count", `OFS_COUNTER, rdv[7:0]);
    end
    test_done();
  end
endmodule
`default_nettype wire
